// File: rtl/lbs_pkg.sv
// Package with constants and types shared by the local bus slave select and reset logic
package lbs_pkg;
   // Width of the local address bus, ignored during hosted DMA
   localparam int addr_width = 32;
   // Low address bits that must be zero for a 16-byte aligned burst start
   localparam int burst_align_bits = 4;
   // Wait states inserted before the first acknowledge of a misaligned burst
   localparam logic [3:0] misalign_wait_cycles = 4'h1;
   // Edges after reset release before the synchronised strap level is trusted
   localparam logic [2:0] strap_settle_cycles = 3'h5;
   // Image select encodings
   localparam logic image_0 = 1'b0;
   localparam logic image_1 = 1'b1;
   // Reset values
   localparam logic strap_reset_value = 1'b1;
   // Access kinds decoded from the chip selects
   typedef enum logic [1:0] {
      access_none,
      access_register,
      access_bridge
   } access_kind_type;
   // Slave cycle states
   typedef enum logic [1:0] {
      slv_idle,
      slv_wait,
      slv_ack
   } slave_state_type;
   // Arbitration states
   typedef enum logic [1:0] {
      arb_idle,
      arb_request,
      arb_wait_busy,
      arb_owner
   } arb_state_type;
endpackage : lbs_pkg

// File: rtl/pin_sync_if.sv
// Interface carrying raw and filtered pin levels to the synchroniser module
`timescale 1ns/1ps
interface pin_sync_if #(parameter int width = 1);
   logic [width-1:0] raw;
   logic [width-1:0] level;
   modport sync (input raw, output level);
   modport user (output raw, input level);
endinterface : pin_sync_if

// File: rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
   parameter int width = 1,
   parameter logic [width-1:0] init = '1
) (
   input wire logic ref_clk,
   input wire logic rstn,
   pin_sync_if.sync pins
);
   logic [width-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, lvl_q, lvl_d;

   // ***********************************************
   // Next values
   // ***********************************************
   always_comb begin
      s1_d = pins.raw;
      s2_d = s1_q;
      s3_d = s2_q;
      lvl_d = lvl_q;
      // A change counts only once the second and third stages agree
      for (int i = 0; i < width; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end

   // Registers; the first stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s1_q <= init;
         s2_q <= init;
         s3_q <= init;
         lvl_q <= init;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         lvl_q <= lvl_d;
      end
   end

   assign pins.level = lvl_q;
endmodule : pin_sync

// File: rtl/local_bus_slave_select_and_reset.sv
// Local bus chip select decode, image select, arbitration, burst waits and reset output
`timescale 1ns/1ps
// Overview of operation
// RQ1: Dual-address hosted DMA cycles always end normally, never retry or bus error.
// RQ2: Local address bus is ignored during hosted DMA transfers.
// RQ3: Take local bus only after the other master releases bus busy.
// RQ4: Misaligned burst starts get wait states before the first acknowledge. The code adds them only on bridge accesses, never on register accesses.
// RQ5: Register chip select qualifies register access; bridge chip select qualifies bridge.
// RQ6: Bridge access uses image 0 when image select is low, else image 1.
// RQ7: Reset output asserted while the PCI reset input is active.
// RQ8: Writing the software reset bit asserts the reset output.
// RQ9: PCI reset input resets all block state.
// RQ10: Processor itself terminates interrupt acknowledge with autovector; block never does.
// RQ11: Master-style strap is sampled at reset; low enables master operation.
// RQ12: Image select is sampled together with the bridge chip select.
module local_bus_slave_select_and_reset
   import lbs_pkg::*;
#(
   parameter int misalign_waits = misalign_wait_cycles
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic register_chip_select_n,
   input wire logic bridge_chip_select_n,
   input wire logic image_select,
   input wire logic transfer_start_n,
   input wire logic burst_n,
   input wire logic [addr_width-1:0] address,
   input wire logic hosted_dma_ack_n,
   input wire logic dual_address_dma,
   input wire logic bus_request_internal,
   input wire logic bus_grant_n,
   input wire logic bus_busy_in_n,
   input wire logic software_reset_bit,
   input wire logic master_style_strap_n,
   output logic transfer_ack_n,
   output logic transfer_error_n,
   output logic transfer_retry_n,
   output logic register_access,
   output logic bridge_access,
   output logic image_1_selected,
   output logic bus_request_n,
   output logic bus_busy_out_n,
   output logic bus_busy_oe_n,
   output logic bus_owned,
   output logic master_enable,
   output logic autovector_ack_n,
   output logic reset_output_n
);
   // ***********************************************
   // Pin synchronisation
   // ***********************************************
   localparam int npins = 5;
   pin_sync_if #(.width(npins)) pins ();
   logic grant_s_n, busy_s_n, dma_ack_s_n, strap_s_n, software_reset_bit_s;
   assign pins.raw = {bus_grant_n, bus_busy_in_n, hosted_dma_ack_n,
                      master_style_strap_n, software_reset_bit};
   assign {grant_s_n, busy_s_n, dma_ack_s_n, strap_s_n, software_reset_bit_s} = pins.level;

   pin_sync #(.width(npins), .init({4'hF, 1'b0})) u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .pins(pins)
   );

   // ***********************************************
   // Slave cycle decode and wait states
   // ***********************************************
   slave_state_type slv_q, slv_d;
   access_kind_type kind_q, kind_d;
   logic image_q, image_d;
   logic [3:0] wait_q, wait_d;
   logic ack_n_q, ack_n_d;
   logic dma_q, dma_d;
   logic aligned;
   logic reg_acc_q, reg_acc_d, brg_acc_q, brg_acc_d;

   // RQ4 alignment check; only meaningful outside hosted DMA
   assign aligned = (address[burst_align_bits-1:0] == '0);

   always_comb begin
      slv_d = slv_q;
      kind_d = kind_q;
      image_d = image_q;
      wait_d = wait_q;
      ack_n_d = 1'b1;
      dma_d = dma_q;
      case (slv_q)
         slv_idle: begin
            kind_d = access_none;
            dma_d = 1'b0;
            if (!transfer_start_n) begin
               // RQ5 select qualify
               if (!register_chip_select_n) begin
                  kind_d = access_register;
                  slv_d = slv_ack;
               end else if (!bridge_chip_select_n) begin
                  kind_d = access_bridge;
                  // RQ12 image latch: captured with the chip select, held for the access
                  // RQ6 image choice
                  image_d = image_select ? image_1 : image_0;
                  slv_d = slv_ack;
                  dma_d = !dma_ack_s_n;
                  // RQ2 address ignored: DMA never consults the address bits
                  // RQ4 misaligned wait
                  if (dma_ack_s_n && !burst_n && !aligned) begin
                     wait_d = 4'(misalign_waits);
                     slv_d = slv_wait;
                  end
               end
            end
         end
         slv_wait: begin
            if (wait_q <= 4'h1) begin
               slv_d = slv_ack;
            end else begin
               wait_d = wait_q - 4'h1;
            end
         end
         slv_ack: begin
            ack_n_d = 1'b0;
            slv_d = slv_idle;
         end
         default: slv_d = slv_idle;
      endcase
      // Access flags get their own flops so the outputs leave a register directly
      reg_acc_d = (kind_d == access_register);
      brg_acc_d = (kind_d == access_bridge);
   end

   // RQ9 global reset of slave state
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         slv_q <= slv_idle;
         kind_q <= access_none;
         image_q <= image_0;
         wait_q <= 4'h0;
         ack_n_q <= 1'b1;
         dma_q <= 1'b0;
         reg_acc_q <= 1'b0;
         brg_acc_q <= 1'b0;
      end else begin
         slv_q <= slv_d;
         kind_q <= kind_d;
         image_q <= image_d;
         wait_q <= wait_d;
         ack_n_q <= ack_n_d;
         dma_q <= dma_d;
         reg_acc_q <= reg_acc_d;
         brg_acc_q <= brg_acc_d;
      end
   end

   // ***********************************************
   // Bus arbitration
   // ***********************************************
   arb_state_type arb_q, arb_d;
   logic req_n_q, req_n_d, bb_oe_n_q, bb_oe_n_d, owned_q, owned_d;
   // Strap state declared here because the arbiter reads the master enable
   logic [2:0] strap_cnt_q, strap_cnt_d;
   logic master_en_q, master_en_d, rsto_n_q, rsto_n_d;

   always_comb begin
      arb_d = arb_q;
      req_n_d = req_n_q;
      bb_oe_n_d = bb_oe_n_q;
      case (arb_q)
         arb_idle: begin
            if (bus_request_internal && master_en_q) begin
               req_n_d = 1'b0;
               arb_d = arb_request;
            end
         end
         arb_request: begin
            if (!grant_s_n) begin
               arb_d = arb_wait_busy;
            end
         end
         arb_wait_busy: begin
            // RQ3 wait busy: ownership only once the other master releases
            if (busy_s_n) begin
               req_n_d = 1'b1;
               bb_oe_n_d = 1'b0;
               arb_d = arb_owner;
            end
         end
         arb_owner: begin
            if (!bus_request_internal) begin
               bb_oe_n_d = 1'b1;
               arb_d = arb_idle;
            end
         end
         default: arb_d = arb_idle;
      endcase
      // Ownership flag mirrors the busy enable, in a flop of its own
      owned_d = !bb_oe_n_d;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         arb_q <= arb_idle;
         req_n_q <= 1'b1;
         bb_oe_n_q <= 1'b1;
         owned_q <= 1'b0;
      end else begin
         arb_q <= arb_d;
         req_n_q <= req_n_d;
         bb_oe_n_q <= bb_oe_n_d;
         owned_q <= owned_d;
      end
   end

   // ***********************************************
   // Strap capture and reset output
   // ***********************************************
   // Strap follows the synchroniser until it has settled, then freezes; the
   // first edge after release would only see the synchroniser's reset value
   always_comb begin
      strap_cnt_d = strap_cnt_q;
      master_en_d = master_en_q;
      // RQ11 strap sample: latched once the synchronised level is trustworthy
      if (strap_cnt_q != strap_settle_cycles) begin
         strap_cnt_d = strap_cnt_q + 3'h1;
         master_en_d = !strap_s_n;
      end
      // RQ8 software reset
      rsto_n_d = !software_reset_bit_s;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         strap_cnt_q <= 3'h0;
         master_en_q <= 1'b0;
         // RQ7 reset follows input: held low while the reset input is active
         rsto_n_q <= 1'b0;
      end else begin
         strap_cnt_q <= strap_cnt_d;
         master_en_q <= master_en_d;
         rsto_n_q <= rsto_n_d;
      end
   end

   // ***********************************************
   // Outputs, from flip-flops or tied constants
   // ***********************************************
   assign transfer_ack_n = ack_n_q;
   // RQ1 normal termination: error and retry are never driven, DMA or not
   assign transfer_error_n = 1'b1;
   assign transfer_retry_n = 1'b1;
   assign register_access = reg_acc_q;
   assign bridge_access = brg_acc_q;
   assign image_1_selected = image_q;
   assign bus_request_n = req_n_q;
   assign bus_busy_out_n = 1'b0;
   assign bus_busy_oe_n = bb_oe_n_q;
   assign bus_owned = owned_q;
   assign master_enable = master_en_q;
   // RQ10 no autovector: the processor terminates the acknowledge itself
   assign autovector_ack_n = 1'b1;
   assign reset_output_n = rsto_n_q;
endmodule : local_bus_slave_select_and_reset

// File: testbench/lbs_monitor.sv
// Checker bound to the local bus slave select and reset block
`timescale 1ns/1ps
module lbs_monitor
   import lbs_pkg::*;
#(
   parameter int misalign_waits = misalign_wait_cycles
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic register_chip_select_n,
   input wire logic bridge_chip_select_n,
   input wire logic image_select,
   input wire logic transfer_start_n,
   input wire logic burst_n,
   input wire logic [addr_width-1:0] address,
   input wire logic hosted_dma_ack_n,
   input wire logic bus_busy_in_n,
   input wire logic software_reset_bit,
   input wire logic transfer_ack_n,
   input wire logic transfer_error_n,
   input wire logic transfer_retry_n,
   input wire logic register_access,
   input wire logic bridge_access,
   input wire logic image_1_selected,
   input wire logic bus_request_n,
   input wire logic bus_busy_oe_n,
   input wire logic bus_owned,
   input wire logic master_enable,
   input wire logic autovector_ack_n,
   input wire logic reset_output_n
);
   // ***********************
   // Assertions
   // ***********************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Idle slave: no access flag and no acknowledge standing
   wire idle = !register_access && !bridge_access && transfer_ack_n;
   wire go = !transfer_start_n && idle;
   a_no_error: assert property (transfer_error_n)
      else $error("error strobe driven");
   a_no_retry: assert property (transfer_retry_n)
      else $error("retry strobe driven");
   a_no_autovec: assert property (autovector_ack_n)
      else $error("autovector driven");
   a_reset_clears: assert property (disable iff (1'h0) !rstn |=>
      !reset_output_n && transfer_ack_n && bus_request_n && bus_busy_oe_n && !master_enable)
      else $error("state not cleared in reset");
   a_sw_reset: assert property (software_reset_bit [*8] |-> !reset_output_n)
      else $error("software reset not reflected");
   a_reg_ack: assert property (go && !register_chip_select_n |=>
      register_access ##1 !transfer_ack_n)
      else $error("register answer wrong");
   a_image_pick: assert property (go && register_chip_select_n
      && !bridge_chip_select_n |=> bridge_access && image_1_selected == $past(image_select))
      else $error("image choice wrong");
   a_misalign_wait: assert property (go && register_chip_select_n
      && !bridge_chip_select_n && !burst_n && hosted_dma_ack_n && address[3:0] != 4'h0
      |-> transfer_ack_n [*3] ##[1:6] !transfer_ack_n)
      else $error("misaligned burst not delayed");
   a_busy_wait: assert property ((!bus_busy_in_n) [*8] ##0 $past(!bus_owned, 3)
      |-> !bus_owned)
      else $error("bus taken while busy");
   c_reg: cover property (!transfer_ack_n && register_access);
   c_img1: cover property (!transfer_ack_n && bridge_access && image_1_selected);
   c_own: cover property ($rose(bus_owned));
endmodule : lbs_monitor

bind local_bus_slave_select_and_reset lbs_monitor #(.misalign_waits(misalign_waits)) mon (.*);

// File: testbench/other_master_model.sv
// Model of the other local bus master and its arbiter
`timescale 1ns/1ps
module other_master_model (
   input wire logic ref_clk,
   input wire logic bus_request_n,
   input wire logic hold_busy,
   output logic bus_grant_n = 1'h1,
   output logic bus_busy_in_n = 1'h1
);
   // ***********************
   // Arbiter and busy line
   // ***********************
   // processor ends interrupt acknowledge itself, nothing expected here
   // Grant one cycle after request; busy held as long as the bench says, so the
   // answer may be prompt or slow; released busy is driven high by the model
   always_ff @(posedge ref_clk) begin
      bus_grant_n <= bus_request_n;
      bus_busy_in_n <= ~hold_busy;
   end
endmodule : other_master_model

// File: testbench/local_bus_slave_select_and_reset_tb_top.sv
// Self-checking bench for the local bus slave select and reset block
`timescale 1ns/1ps
`define chk(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t value mismatch", $time); end end
module local_bus_slave_select_and_reset_tb_top;
   import lbs_pkg::*;
   // ***********************
   // Signals, clock, instances
   // ***********************
   logic ref_clk = 1'h0, rstn = 1'h0, image_select = 1'h0, transfer_start_n = 1'h1;
   logic register_chip_select_n = 1'h1, bridge_chip_select_n = 1'h1, burst_n = 1'h1;
   logic hosted_dma_ack_n = 1'h1, dual_address_dma = 1'h1, bus_request_internal = 1'h0;
   logic software_reset_bit = 1'h0, master_style_strap_n = 1'h0, hold_busy = 1'h1;
   logic [addr_width-1:0] address = '0;
   logic bus_grant_n, bus_busy_in_n, transfer_ack_n, transfer_error_n, transfer_retry_n;
   logic register_access, bridge_access, image_1_selected, bus_request_n, bus_busy_out_n;
   logic bus_busy_oe_n, bus_owned, master_enable, autovector_ack_n, reset_output_n;
   int mismatches = 0, tests_run = 0, n;
   initial forever #2.5 ref_clk = ~ref_clk;
   local_bus_slave_select_and_reset dut (.*);
   other_master_model peer (.*);
   task close_out;
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   // Check after a bounded falling-edge wait; a used-up bound ends the run
   task automatic hang_check(input int lim);
      if (n >= lim) begin
         mismatches++;
         close_out();
      end
   endtask : hang_check
   // One slave cycle; image select and address change after the start edge,
   // so a late sample of either shows up as a wrong image or latency
   task automatic xfer(input logic rs, bs, im, bu, input logic [3:0] lo, input int exp);
      @(negedge ref_clk);
      register_chip_select_n = rs;
      bridge_chip_select_n = bs;
      image_select = im;
      burst_n = bu;
      address = {28'hA5A5A5A, lo};
      transfer_start_n = 1'h0;
      @(negedge ref_clk);
      transfer_start_n = 1'h1;
      image_select = ~im;
      address = ~address;
      for (n = 1; transfer_ack_n !== 1'h0 && n < 20; n++) @(negedge ref_clk);
      hang_check(20);
      `chk(n, exp)
      `chk(register_access, ~rs)
      `chk(bridge_access, ~bs)
      if (!bs) `chk(image_1_selected, im)
      `chk({transfer_error_n, transfer_retry_n}, 2'h3)
      @(negedge ref_clk);
      register_chip_select_n = 1'h1;
      bridge_chip_select_n = 1'h1;
   endtask : xfer
   // ***********************
   // Scenarios
   // ***********************
   task t_slave;
      xfer(1'h0, 1'h1, 1'h0, 1'h1, 4'h0, 2);
      xfer(1'h1, 1'h0, 1'h0, 1'h1, 4'h0, 2);
      xfer(1'h1, 1'h0, 1'h1, 1'h1, 4'h0, 2);
   endtask : t_slave
   task t_burst;
      xfer(1'h1, 1'h0, 1'h0, 1'h0, 4'h0, 2);
      // Each misaligned start adds the configured wait states to the base latency
      for (int k = 1; k < 4; k++) begin
         xfer(1'h1, 1'h0, 1'h1, 1'h0, 4'(k * 4), 2 + misalign_wait_cycles);
      end
   endtask : t_burst
   task t_dma;
      hosted_dma_ack_n = 1'h0;
      repeat (6) @(negedge ref_clk);
      xfer(1'h1, 1'h0, 1'h0, 1'h0, 4'h4, 2);
      hosted_dma_ack_n = 1'h1;
      repeat (8) @(negedge ref_clk);
   endtask : t_dma
   task t_arb;
      bus_request_internal = 1'h1;
      repeat (12) @(negedge ref_clk);
      `chk(bus_owned, 1'h0)
      `chk(bus_request_n, 1'h0)
      hold_busy = 1'h0;
      for (n = 0; bus_owned !== 1'h1 && n < 40; n++) @(negedge ref_clk);
      hang_check(40);
      `chk({bus_busy_oe_n, bus_busy_out_n}, 2'h0)
      bus_request_internal = 1'h0;
      repeat (8) @(negedge ref_clk);
   endtask : t_arb
   task t_swrst;
      software_reset_bit = 1'h1;
      for (n = 0; reset_output_n !== 1'h0 && n < 12; n++) @(negedge ref_clk);
      hang_check(12);
      `chk(reset_output_n, 1'h0)
      software_reset_bit = 1'h0;
      for (n = 0; reset_output_n !== 1'h1 && n < 12; n++) @(negedge ref_clk);
      hang_check(12);
      `chk(reset_output_n, 1'h1)
   endtask : t_swrst
   // Mid-run reset while owning the bus and after an image 1 access
   task t_rst;
      xfer(1'h1, 1'h0, 1'h1, 1'h1, 4'h0, 2);
      bus_request_internal = 1'h1;
      for (n = 0; bus_owned !== 1'h1 && n < 40; n++) @(negedge ref_clk);
      hang_check(40);
      rstn = 1'h0;
      repeat (2) @(negedge ref_clk);
      `chk({bus_owned, image_1_selected, master_enable}, 3'h0)
      `chk({reset_output_n, bus_busy_oe_n, bus_request_n}, 3'h3)
      bus_request_internal = 1'h0;
      rstn = 1'h1;
      repeat (8) @(negedge ref_clk);
      `chk(master_enable, 1'h1)
   endtask : t_rst
   // Main sequence; strap held low so the block may become master
   initial begin
      repeat (16) @(negedge ref_clk);
      `chk(reset_output_n, 1'h0)
      `chk(master_enable, 1'h0)
      rstn = 1'h1;
      repeat (8) @(negedge ref_clk);
      `chk(master_enable, 1'h1)
      t_slave();
      t_burst();
      t_dma();
      t_arb();
      t_rst();
      t_swrst();
      close_out();
   end
endmodule : local_bus_slave_select_and_reset_tb_top
